// file: logic/emr_cfg.svh
// constants for the error message routing block: offsets, fields, resets
// assumes inclusion by bare name from the package and design files
`ifndef EMR_CFG_SVH
`define EMR_CFG_SVH

`define EMR_ADDR_W 8
`define EMR_OFS_SMI_EN 8'h66
`define EMR_OFS_SCI_EN 8'h67
`define EMR_OFS_CAP_DIS 8'hf4
`define EMR_OFS_SERR_EN 8'h5c
`define EMR_OFS_FLAGS 8'h5e
`define EMR_OFS_CAP_VIEW 8'hf8
`define EMR_EN_MASK 8'h0b
`define EMR_EN_RESET 8'h00
`define EMR_CAP_DIS_MASK 32'h00000fff
`define EMR_CAP_DIS_RESET 12'h000
`define EMR_CAP_BITS 12
`define EMR_CAP_LSB 28
`define EMR_FLAG_W 8
`define EMR_THERM_BIT 3
`define EMR_MSG_BUSY_CYC 4'h3

`endif

// file: logic/emr_pkg.sv
// types for the error message routing block
// assumes emr_cfg.svh is on the include path
`include "emr_cfg.svh"
package emr_pkg;
  // kind of special cycle carried on the hub link
  typedef enum logic [1:0] {
    EMR_MSG_NONE,
    EMR_MSG_SERR,
    EMR_MSG_SMI,
    EMR_MSG_SCI
  } emr_msg_type;

  typedef enum logic [0:0] {
    EMR_ST_IDLE,
    EMR_ST_SEND
  } emr_state_type;
endpackage : emr_pkg

// file: logic/emr_pick.sv
// picks one pending error flag and its single message type
// assumes flag, enable vectors come from the same clock domain
module emr_pick #(
  parameter int W = 8
) (
  // pending flags and per-type enables
  input wire logic [W-1:0] i_pending,
  input wire logic [W-1:0] i_serr_en,
  input wire logic [W-1:0] i_smi_en,
  input wire logic [W-1:0] i_sci_en,
  // chosen flag and message
  output logic o_found,
  output logic [$clog2(W)-1:0] o_index,
  output emr_pkg::emr_msg_type o_msg
);
  // lowest pending flag wins; one message type per flag, serr first
  always_comb begin
    o_found = 1'b0;
    o_index = '0;
    o_msg = emr_pkg::EMR_MSG_NONE;
    for (int i = W - 1; i >= 0; i--) begin
      if (i_pending[i]) begin
        o_found = 1'b1;
        o_index = ($clog2(W))'(i);
        if (i_serr_en[i]) begin
          o_msg = emr_pkg::EMR_MSG_SERR;
        end else if (i_smi_en[i]) begin
          o_msg = emr_pkg::EMR_MSG_SMI;
        end else begin
          o_msg = emr_pkg::EMR_MSG_SCI;
        end
      end
    end
  end
endmodule : emr_pick

// file: logic/emr_route.sv
// error message routing: registers, error latches, special cycle sender
// assumes error events are one-cycle pulses on i_clock; straps are pins
//
// Design decision made here: the address-and-strobe port.
`include "emr_cfg.svh"
module emr_route #(
  parameter int FLAG_W = `EMR_FLAG_W,
  parameter int CAP_W = `EMR_CAP_BITS
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // register port
  input wire logic [`EMR_ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // error events and straps
  input wire logic [FLAG_W-1:0] i_error_event,
  input wire logic [CAP_W-1:0] i_cap_strap,
  // special cycle request toward the hub link
  output logic o_msg_valid,
  output emr_pkg::emr_msg_type o_msg_type,
  input wire logic i_msg_ready,
  // capability bits 39:28 as seen by the capability register
  output logic [CAP_W-1:0] o_cap_disabled
);
  localparam int IW = $clog2(FLAG_W);

  // all state in one record
  typedef struct packed {
    logic [7:0] smi_en;
    logic [7:0] sci_en;
    logic [7:0] serr_en;
    logic [CAP_W-1:0] cap_dis;
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] pending;
    logic [2:0][CAP_W-1:0] strap_sync;
    logic [CAP_W-1:0] strap_q;
    logic [CAP_W-1:0] cap_out;
    logic [31:0] rdata;
    logic msg_valid;
    emr_pkg::emr_msg_type msg_type;
    emr_pkg::emr_state_type state;
  } emr_state_rec_type;

  emr_state_rec_type st_q;
  emr_state_rec_type st_d;

  logic pick_found;
  logic [IW-1:0] pick_index;
  emr_pkg::emr_msg_type pick_msg;
  logic [FLAG_W-1:0] smi_en_w;
  logic [FLAG_W-1:0] sci_en_w;
  logic [FLAG_W-1:0] serr_en_w;
  logic [FLAG_W-1:0] routable;

  // widen enables to flag width
  assign smi_en_w = FLAG_W'(st_q.smi_en);
  assign sci_en_w = FLAG_W'(st_q.sci_en);
  assign serr_en_w = FLAG_W'(st_q.serr_en);
  // a flag only needs a message if some type enables it
  assign routable = st_q.pending & (smi_en_w | sci_en_w | serr_en_w);

  emr_pick #(
    .W(FLAG_W)
  ) u_pick (
    .i_pending(routable),
    .i_serr_en(serr_en_w),
    .i_smi_en(smi_en_w),
    .i_sci_en(sci_en_w),
    .o_found(pick_found),
    .o_index(pick_index),
    .o_msg(pick_msg)
  );

  // next state
  always_comb begin
    logic [31:0] wmask;
    logic [FLAG_W-1:0] clr;
    wmask = '0;
    clr = '0;
    st_d = st_q;

    // straps pass three flops; a change counts once stages two and three agree
    st_d.strap_sync[0] = i_cap_strap;
    st_d.strap_sync[1] = st_q.strap_sync[0];
    st_d.strap_sync[2] = st_q.strap_sync[1];
    if (st_q.strap_sync[1] == st_q.strap_sync[2]) begin
      st_d.strap_q = st_q.strap_sync[2];
    end
    // or only: a disable can remove a capability, never restore one
    st_d.cap_out = st_q.strap_q | st_q.cap_dis;

    // register writes; reserved bits masked off
    if (i_wr) begin
      case (i_addr)
        `EMR_OFS_SMI_EN: st_d.smi_en = i_wdata[7:0] & `EMR_EN_MASK;
        `EMR_OFS_SCI_EN: st_d.sci_en = i_wdata[7:0] & `EMR_EN_MASK;
        `EMR_OFS_SERR_EN: st_d.serr_en = i_wdata[7:0];
        `EMR_OFS_CAP_DIS: begin
          wmask = i_wdata & `EMR_CAP_DIS_MASK;
          st_d.cap_dis = wmask[CAP_W-1:0];
        end
        `EMR_OFS_FLAGS: clr = i_wdata[FLAG_W-1:0];
        default: ;
      endcase
    end

    // write one to clear; a new event in the same cycle wins
    st_d.flags = (st_q.flags & ~clr) | i_error_event;

    // each flag holds at most one pending request, dropped when its message is offered
    st_d.pending = st_q.pending | i_error_event;

    // sender: one special cycle per pending flag, one type only
    case (st_q.state)
      emr_pkg::EMR_ST_IDLE: begin
        if (pick_found) begin
          st_d.msg_valid = 1'b1;
          st_d.msg_type = pick_msg;
          st_d.pending[pick_index] = i_error_event[pick_index];
          st_d.state = emr_pkg::EMR_ST_SEND;
        end
      end
      emr_pkg::EMR_ST_SEND: begin
        if (i_msg_ready) begin
          st_d.msg_valid = 1'b0;
          st_d.msg_type = emr_pkg::EMR_MSG_NONE;
          st_d.state = emr_pkg::EMR_ST_IDLE;
        end
      end
      default: st_d.state = emr_pkg::EMR_ST_IDLE;
    endcase

    // flags with no enable at all keep a pending request only until one cycle after the event
    st_d.pending = st_d.pending & (smi_en_w | sci_en_w | serr_en_w | i_error_event);

    // read data one cycle after the strobe, zero otherwise
    st_d.rdata = '0;
    if (i_rd) begin
      case (i_addr)
        `EMR_OFS_SMI_EN: st_d.rdata = {24'h000000, st_q.smi_en};
        `EMR_OFS_SCI_EN: st_d.rdata = {24'h000000, st_q.sci_en};
        `EMR_OFS_SERR_EN: st_d.rdata = {24'h000000, st_q.serr_en};
        `EMR_OFS_CAP_DIS: st_d.rdata = 32'(st_q.cap_dis);
        `EMR_OFS_FLAGS: st_d.rdata = 32'(st_q.flags);
        `EMR_OFS_CAP_VIEW: st_d.rdata = 32'(st_q.cap_out);
        default: st_d.rdata = 32'h00000000;
      endcase
    end
  end

  // register the record
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      st_q <= '0;
      st_q.msg_type <= emr_pkg::EMR_MSG_NONE;
      st_q.state <= emr_pkg::EMR_ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign o_rdata = st_q.rdata;
  assign o_msg_valid = st_q.msg_valid;
  assign o_msg_type = st_q.msg_type;
  assign o_cap_disabled = st_q.cap_out;
endmodule : emr_route

// file: dv/emr_route_sva.sv
// port assertions for the routing block
// assumes a bind onto every emr_route
module emr_route_sva #(
  parameter int CAP_W = 12
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // link and straps
  input wire logic o_msg_valid,
  input emr_pkg::emr_msg_type o_msg_type,
  input wire logic i_msg_ready,
  input wire logic [CAP_W-1:0] i_cap_strap,
  input wire logic [CAP_W-1:0] o_cap_disabled
);
  timeunit 1ns / 1ns;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // offer waits for the link, accept ends it
  sequence s_wait; o_msg_valid && !i_msg_ready; endsequence
  sequence s_take; o_msg_valid && i_msg_ready; endsequence
  chk_msg_hold: assert property (s_wait |=> o_msg_valid && $stable(o_msg_type))
    else $error("message dropped early");
  chk_one_cycle: assert property (s_take |=> !o_msg_valid)
    else $error("message repeated");
  chk_msg_kind: assert property (o_msg_valid |-> o_msg_type != emr_pkg::EMR_MSG_NONE)
    else $error("message without kind");
  chk_en_rsvd: assert property (i_rd && i_addr inside {8'h66, 8'h67}
    |=> (o_rdata & ~32'h0b) == 32'h0)
    else $error("enable reserved bits set");
  chk_cap_rsvd: assert property (i_rd && i_addr == 8'hf4 |=> o_rdata[31:12] == 20'h0)
    else $error("disable reserved bits set");
  chk_rst_quiet: assert property ($rose(i_rst_n) |-> !o_msg_valid)
    else $error("message right after reset");
  chk_dis_force: assert property (i_wr && i_addr == 8'hf4 && i_wdata[CAP_W-1:0] == '1
    |-> ##[1:3] o_cap_disabled == '1)
    else $error("disable did not force off");
  chk_strap_or: assert property (i_cap_strap == '1 [*7] |-> o_cap_disabled == '1)
    else $error("strap not passed on");
endmodule : emr_route_sva
bind emr_route emr_route_sva #(.CAP_W(CAP_W)) sva (.i_clock, .i_rst_n, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .o_msg_valid, .o_msg_type, .i_msg_ready, .i_cap_strap,
  .o_cap_disabled);

// file: dv/emr_link_model.sv
// far hub model: takes special cycles, promptly or after a stall
// assumes valid and kind hold until ready is seen
module emr_link_model (
  // clock and controls
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_slow,
  // message link
  input wire logic i_msg_valid,
  output logic o_msg_ready,
  output int o_count
);
  timeunit 1ns / 1ns;
  int wait_q;
  // slow hub stalls two cycles; accepted messages are counted
  always @(posedge i_clock) begin
    if (!i_rst_n || !i_msg_valid || o_msg_ready) wait_q <= 0;
    else wait_q <= wait_q + 1;
    if (!i_rst_n) o_count <= 0;
    else if (i_msg_valid && o_msg_ready) o_count <= o_count + 1;
  end
  // ready only while offered, so it never shows a stale accept
  assign o_msg_ready = i_msg_valid && (!i_slow || wait_q >= 2);
endmodule : emr_link_model

// file: dv/test_error_message_routing.sv
// self-checking bench for the routing block
// assumes the link model and checker are compiled first
module test_error_message_routing;
  timeunit 1ns / 1ns;
  logic i_clock = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, slow = 0, i_msg_ready, o_msg_valid;
  logic [7:0] i_addr = 8'h00, i_error_event = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, rd_q;
  logic [11:0] i_cap_strap = 12'h000, o_cap_disabled;
  emr_pkg::emr_msg_type o_msg_type;
  int fail_count = 0, checked = 0, msgs;
  emr_route dut (.i_clock, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_error_event, .i_cap_strap, .o_msg_valid, .o_msg_type, .i_msg_ready, .o_cap_disabled);
  emr_link_model link (.i_clock, .i_rst_n, .i_slow(slow), .i_msg_valid(o_msg_valid),
    .o_msg_ready(i_msg_ready), .o_count(msgs));
  initial forever #50 i_clock = ~i_clock;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %h not %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    {i_wr, i_addr, i_wdata} <= {1'h1, a, d};
    @(posedge i_clock);
    i_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge i_clock);
    {i_rd, i_addr} <= {1'h1, a};
    @(posedge i_clock);
    i_rd <= 1'h0;
    #1 rd_q = o_rdata;
  endtask : rd
  // reset values, then reserved bits and an unmapped place
  task automatic t_regs();
    logic [7:0] offs [4] = '{8'h66, 8'h67, 8'hf4, 8'h10};
    logic [31:0] keep [4] = '{32'h08, 32'h08, 32'hffc, 32'h0};
    foreach (offs[i]) begin
      rd(offs[i]);
      chk(rd_q, 32'h0);
      wr(offs[i], 32'hfffffffc);
      rd(offs[i]);
      chk(rd_q, keep[i]);
      wr(offs[i], 32'h0);
    end
  endtask : t_regs
  // one thermal trip gives one message of the enabled kind only
  task automatic t_msg(input logic [7:0] a, input emr_pkg::emr_msg_type k, input logic s);
    int n;
    slow <= s;
    wr(a, 32'h08);
    n = msgs;
    @(posedge i_clock);
    i_error_event <= 8'h08;
    @(posedge i_clock);
    i_error_event <= 8'h00;
    // a prompt hub takes the offer at the next edge, so look in its first cycle
    repeat (1) @(posedge i_clock);
    #1 chk(32'({o_msg_valid, o_msg_type}), 32'({k != emr_pkg::EMR_MSG_NONE, k}));
    repeat (6) @(posedge i_clock);
    chk(msgs - n, k != emr_pkg::EMR_MSG_NONE);
    wr(a, 32'h0);
  endtask : t_msg
  // straps or disable bits; a clear bit never restores a strapped one
  task automatic t_cap();
    i_cap_strap <= 12'hfff;
    repeat (8) @(posedge i_clock);
    #1 chk(32'(o_cap_disabled), 32'hfff);
    i_cap_strap <= 12'h0a5;
    wr(8'hf4, 32'hfff);
    wr(8'hf4, 32'h050);
    repeat (8) @(posedge i_clock);
    #1 chk(32'(o_cap_disabled), 32'h0f5);
  endtask : t_cap
  task automatic finish_test();
    if (fail_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // main sequence
  initial begin
    repeat (4) @(posedge i_clock);
    i_rst_n <= 1'h1;
    t_regs();
    t_msg(8'h66, emr_pkg::EMR_MSG_SMI, 1'h0);
    t_msg(8'h67, emr_pkg::EMR_MSG_SCI, 1'h1);
    t_msg(8'h5c, emr_pkg::EMR_MSG_SERR, 1'h1);
    t_msg(8'h10, emr_pkg::EMR_MSG_NONE, 1'h0);
    t_cap();
    finish_test();
  end
  // watchdog, far beyond the hundred or so cycles the tests need
  initial begin
    #400000;
    fail_count++;
    finish_test();
  end
endmodule : test_error_message_routing
